// >>> tdm_pkg.sv
// shared constants, register map and carrier types of the drive monitor
package tdm_pkg;

  ////////////////////////////////////////////////////////////////////////
  // bus widths and answers
  localparam int          ADDR_W      = 16;
  localparam int          DATA_W      = 32;
  localparam int          REG_W       = 8;
  localparam logic [1:0]  RESP_OK     = 2'h0;
  localparam logic [1:0]  RESP_DECODE = 2'h3;

  ////////////////////////////////////////////////////////////////////////
  // register indices; the byte address is four times the index
  localparam logic [13:0] IDX_INT_STATUS = 14'h1302;
  localparam logic [13:0] IDX_ALARM      = 14'h1303;
  localparam logic [13:0] IDX_TX_CTRL    = 14'h1304;
  localparam logic [13:0] IDX_INT_MASK   = 14'h1310;

  ////////////////////////////////////////////////////////////////////////
  // transmit control fields
  localparam int          TXC_LEVEL    = 0;
  localparam int          TXC_ALL_ONES = 2;
  localparam int          TXC_INTERNAL = 5;
  localparam logic [7:0]  TXC_WMASK    = 8'h25;
  localparam logic [7:0]  TXC_RST      = 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // interrupt status and mask fields
  localparam int          INT_DRIVE    = 0;
  localparam int          INT_SIGNAL   = 1;
  localparam int          INT_LOCK     = 2;
  localparam int          INT_FIFO     = 3;
  localparam logic [7:0]  INT_WMASK    = 8'h0f;
  localparam logic [7:0]  INT_STAT_RST = 8'h00;
  localparam logic [7:0]  INT_MASK_RST = 8'h0f;

  ////////////////////////////////////////////////////////////////////////
  // alarm status fields
  localparam int          AL_DRIVE     = 0;
  localparam int          AL_SIGNAL    = 1;
  localparam int          AL_LOCK      = 2;
  localparam int          AL_FIFO      = 3;
  localparam int          AL_ANALOG    = 4;
  localparam int          AL_DIGITAL   = 5;

  ////////////////////////////////////////////////////////////////////////
  // silence interval in line bit periods
  localparam int          SILENCE_BITS = 128;

  ////////////////////////////////////////////////////////////////////////
  // carrier types
  typedef struct packed {
    logic              read;
    logic              write;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata;
    logic [3:0]        byteenable;
  } tdm_avs_req_t;

  typedef struct packed {
    logic digital_loss;
    logic analog_loss;
    logic fifo_limit;
    logic lock_loss;
    logic signal_loss;
  } tdm_alarm_t;

  typedef enum logic [0:0] {
    MON_CLEAR = 1'b0,
    MON_FAULT = 1'b1
  } tdm_mon_state_t;

endpackage : tdm_pkg

// >>> tdm_silence_det.sv
// silence counter: flags a run of line bit periods with no pulse
`timescale 1ns/1ps
module tdm_silence_det #(
  parameter int LIMIT = tdm_pkg::SILENCE_BITS
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  // line side
  input  wire logic bit_en,
  input  wire logic pulse,
  // result
  output logic      expired
);

  localparam int CNT_W = $clog2(LIMIT + 1);
  localparam logic [CNT_W-1:0] TERM = CNT_W'(LIMIT);
  localparam logic [CNT_W-1:0] ONE  = CNT_W'(1);

  // the counter cannot time a run shorter than two bits
  if (LIMIT < 2) begin : g_bad_limit
    $error("tdm_silence_det: LIMIT must be at least 2");
  end

  logic [CNT_W-1:0] count;
  wire              at_term = (count == TERM);
  wire [CNT_W-1:0]  next_count = pulse ? '0 :
                                 (bit_en && !at_term) ? count + ONE :
                                 count;

  ////////////////////////////////////////////////////////////////////////
  // counts bit periods; any pulse restarts it, it saturates at term
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count   <= '0;
      expired <= 1'b0;
    end else if (clk_en) begin
      count   <= next_count;
      expired <= (next_count == TERM);
    end
  end

endmodule : tdm_silence_det

// >>> tdm_top.sv
// transmit drive monitor with line interface status registers
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ps
module tdm_top #(
  parameter int SILENCE_BITS = tdm_pkg::SILENCE_BITS
) (
  // clock, reset, enable
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  input  wire logic                 clk_en,
  // avalon-mm slave
  input  wire tdm_pkg::tdm_avs_req_t avs,
  output logic [31:0]               avs_readdata,
  output logic [1:0]                avs_response,
  output logic                      avs_waitrequest,
  // transmit line
  input  wire logic                 tx_bit_en,
  input  wire logic                 tx_pos_data,
  input  wire logic                 tx_neg_data,
  output logic                      tx_line_pos_out,
  output logic                      tx_line_neg_out,
  output logic                      transmit_level_select,
  // external monitor inputs
  input  wire logic                 monitor_pos_in,
  input  wire logic                 monitor_neg_in,
  // alarm levels from the receive side
  input  wire tdm_pkg::tdm_alarm_t  alarms,
  // status outputs
  output logic                      drive_fault,
  output logic                      irq_n
);

  ////////////////////////////////////////////////////////////////////////
  // register state
  logic [7:0]              tx_ctrl;
  logic [7:0]              int_status;
  logic [7:0]              int_mask;
  logic                    ones_phase;
  tdm_pkg::tdm_mon_state_t mon_state;
  tdm_pkg::tdm_alarm_t     alarms_q;
  logic                    silence_expired;

  ////////////////////////////////////////////////////////////////////////
  // address decode; unaligned or unknown words are unmapped
  wire        req        = avs.read | avs.write;
  wire        accept     = req & avs_waitrequest;
  wire        done       = req & ~avs_waitrequest;
  wire [13:0] idx        = avs.address[15:2];
  wire        aligned    = (avs.address[1:0] == 2'h0);
  wire        hit_status = aligned && (idx == tdm_pkg::IDX_INT_STATUS);
  wire        hit_alarm  = aligned && (idx == tdm_pkg::IDX_ALARM);
  wire        hit_ctrl   = aligned && (idx == tdm_pkg::IDX_TX_CTRL);
  wire        hit_mask   = aligned && (idx == tdm_pkg::IDX_INT_MASK);
  wire        hit_any    = hit_status | hit_alarm | hit_ctrl | hit_mask;
  wire        wr_low     = done & avs.write & avs.byteenable[0];
  wire [7:0]  wdata      = avs.writedata[7:0];

  ////////////////////////////////////////////////////////////////////////
  // monitored point: pads in internal mode, monitor pins otherwise
  wire internal_mode = tx_ctrl[tdm_pkg::TXC_INTERNAL];
  wire pad_pulse     = tx_line_pos_out | tx_line_neg_out;
  wire ext_pulse     = monitor_pos_in | monitor_neg_in;
  wire line_pulse    = internal_mode ? pad_pulse : ext_pulse;

  ////////////////////////////////////////////////////////////////////////
  // silence timer at the line bit rate
  tdm_silence_det #(
    .LIMIT   (SILENCE_BITS)
  ) u_silence (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .bit_en  (tx_bit_en),
    .pulse   (line_pulse),
    .expired (silence_expired)
  );

  ////////////////////////////////////////////////////////////////////////
  // fault state: declare on expiry, clear on the first pulse seen
  wire declare = (mon_state == tdm_pkg::MON_CLEAR) &&
                 silence_expired && !line_pulse;
  wire clear   = (mon_state == tdm_pkg::MON_FAULT) &&
                 line_pulse;
  tdm_pkg::tdm_mon_state_t next_mon_state;

  always_comb begin
    next_mon_state = mon_state;
    case (mon_state)
      tdm_pkg::MON_CLEAR: begin
        if (declare) begin
          next_mon_state = tdm_pkg::MON_FAULT;
        end
      end
      tdm_pkg::MON_FAULT: begin
        if (clear) begin
          next_mon_state = tdm_pkg::MON_CLEAR;
        end
      end
      default: begin
        next_mon_state = tdm_pkg::MON_CLEAR;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // change events: both edges of the fault and of the signal, lock and fifo alarms
  wire       drive_change = declare | clear;
  wire [7:0] set_events;

  assign set_events[tdm_pkg::INT_DRIVE]  = drive_change;
  assign set_events[tdm_pkg::INT_SIGNAL] =
    alarms.signal_loss ^ alarms_q.signal_loss;
  assign set_events[tdm_pkg::INT_LOCK]   =
    alarms.lock_loss ^ alarms_q.lock_loss;
  assign set_events[tdm_pkg::INT_FIFO]   =
    alarms.fifo_limit ^ alarms_q.fifo_limit;
  assign set_events[7:4] = 4'h0;

  ////////////////////////////////////////////////////////////////////////
  // alarm status view, read only; bits 7..6 read zero
  wire [7:0] alarm_view;

  assign alarm_view[tdm_pkg::AL_DRIVE]   =
    (mon_state == tdm_pkg::MON_FAULT);
  assign alarm_view[tdm_pkg::AL_SIGNAL]  = alarms.signal_loss;
  assign alarm_view[tdm_pkg::AL_LOCK]    = alarms.lock_loss;
  assign alarm_view[tdm_pkg::AL_FIFO]    = alarms.fifo_limit;
  assign alarm_view[tdm_pkg::AL_ANALOG]  = alarms.analog_loss;
  assign alarm_view[tdm_pkg::AL_DIGITAL] = alarms.digital_loss;
  assign alarm_view[7:6] = 2'h0;

  ////////////////////////////////////////////////////////////////////////
  // read data mux, captured in the accept cycle so it stands at done
  wire [7:0] rd_sel =
    hit_status ? int_status :
    hit_alarm  ? alarm_view :
    hit_ctrl   ? tx_ctrl :
    hit_mask   ? int_mask :
    8'h00;
  wire [31:0] next_readdata = {24'h000000, rd_sel};
  wire [1:0]  next_response = hit_any ? tdm_pkg::RESP_OK :
                                        tdm_pkg::RESP_DECODE;

  ////////////////////////////////////////////////////////////////////////
  // status clear: only bits actually returned by the read are dropped,
  // so an event landing between accept and done survives; a write of
  // one also clears. a set in the same cycle always wins.
  wire       rd_clr  = done & avs.read & hit_status;
  wire [7:0] clr_rd  = rd_clr ? (avs_readdata[7:0] &
                                 tdm_pkg::INT_WMASK) : 8'h00;
  wire [7:0] clr_wr  = (wr_low & hit_status) ?
                       (wdata & tdm_pkg::INT_WMASK) : 8'h00;
  wire [7:0] next_int_status =
    (int_status & ~(clr_rd | clr_wr)) | set_events;

  wire [7:0] next_int_mask = (wr_low & hit_mask) ?
                             (wdata & tdm_pkg::INT_WMASK) : int_mask;
  wire [7:0] next_tx_ctrl  = (wr_low & hit_ctrl) ?
                             (wdata & tdm_pkg::TXC_WMASK) :
                             tx_ctrl;

  // irq follows the next status so it drops with the status bit
  wire next_irq_n = ~|(next_int_status & next_int_mask);

  ////////////////////////////////////////////////////////////////////////
  // line output: all-ones sends alternating marks, else encoder data
  wire all_ones = tx_ctrl[tdm_pkg::TXC_ALL_ONES];
  wire next_pos = all_ones ? ones_phase : tx_pos_data;
  wire next_neg = all_ones ? ~ones_phase : tx_neg_data;

  ////////////////////////////////////////////////////////////////////////
  // bus handshake: waitrequest idles high and drops for one cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
      avs_response    <= 2'h0;
    end else if (clk_en) begin
      avs_waitrequest <= ~accept;
      if (accept) begin
        avs_readdata <= next_readdata;
        avs_response <= next_response;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // software registers and interrupt output
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_ctrl    <= tdm_pkg::TXC_RST;
      int_status <= tdm_pkg::INT_STAT_RST;
      int_mask   <= tdm_pkg::INT_MASK_RST;
      irq_n      <= 1'b1;
    end else if (clk_en) begin
      tx_ctrl    <= next_tx_ctrl;
      int_status <= next_int_status;
      int_mask   <= next_int_mask;
      irq_n      <= next_irq_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // monitor state and alarm history for edge detection
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mon_state   <= tdm_pkg::MON_CLEAR;
      drive_fault <= 1'b0;
      alarms_q    <= '0;
    end else if (clk_en) begin
      mon_state   <= next_mon_state;
      drive_fault <= (next_mon_state == tdm_pkg::MON_FAULT);
      alarms_q    <= alarms;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmit pads update once per bit period
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_line_pos_out       <= 1'b0;
      tx_line_neg_out       <= 1'b0;
      ones_phase            <= 1'b0;
      transmit_level_select <= 1'b0;
    end else if (clk_en) begin
      transmit_level_select <= next_tx_ctrl[tdm_pkg::TXC_LEVEL];
      if (tx_bit_en) begin
        tx_line_pos_out <= next_pos;
        tx_line_neg_out <= next_neg;
        ones_phase      <= ~ones_phase;
      end
    end
  end

endmodule : tdm_top

// >>> tdm_top_assertions.sv
// concurrent checks on the drive monitor's ports
`timescale 1ns/1ps
module tdm_top_assertions #(
  parameter int SILENCE_BITS = tdm_pkg::SILENCE_BITS
) (
  // clock and reset
  input wire logic                  ref_clk,
  input wire logic                  rst_n,
  input wire logic                  clk_en,
  // register bus
  input wire tdm_pkg::tdm_avs_req_t avs,
  input wire logic [31:0]           avs_readdata,
  input wire logic                  avs_waitrequest,
  // line side
  input wire logic                  tx_bit_en,
  input wire logic                  tx_line_pos_out,
  input wire logic                  tx_line_neg_out,
  input wire logic                  transmit_level_select,
  // status
  input wire logic                  drive_fault,
  input wire logic                  irq_n
);
  localparam logic [15:0] A_IS = {tdm_pkg::IDX_INT_STATUS, 2'b00};
  localparam logic [15:0] A_TC = {tdm_pkg::IDX_TX_CTRL, 2'b00};
  logic fault_q;
  int   bits_seen;

  ////////////////////////////////////////////////////////////////////////
  // bit periods since reset or last clear; the design restarts on the
  // pulse an edge earlier, hence one period of slack below
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_q   <= 1'b0;
      bits_seen <= 0;
    end else if (clk_en) begin
      fault_q   <= drive_fault;
      bits_seen <= (fault_q && !drive_fault) ? 0 : bits_seen + tx_bit_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n || !clk_en);
  sequence s_accept;
    (avs.read || avs.write) && avs_waitrequest;
  endsequence
  sequence s_ctrl_write;
    s_accept ##0 (avs.write && avs.address == A_TC && avs.byteenable[0]);
  endsequence

  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest held low past one cycle");
  a_status_upper: assert property (
    s_accept ##0 (avs.read && avs.address == A_IS)
    |=> avs_readdata[7:4] == 4'h0)
    else $error("status upper bits not zero");
  a_ctrl_zero: assert property (
    s_accept ##0 (avs.read && avs.address == A_TC)
    |=> (avs_readdata[7:0] & ~tdm_pkg::TXC_WMASK) == 8'h00)
    else $error("control spare bits not zero");
  a_ctrl_level: assert property (
    s_ctrl_write |-> ##2 transmit_level_select == $past(avs.writedata[0], 2))
    else $error("level pin does not follow control bit 0");
  a_declare_irq: assert property ($rose(drive_fault) |-> !irq_n)
    else $error("fault declared without interrupt");
  a_clear_irq: assert property ($fell(drive_fault) |-> !irq_n)
    else $error("fault cleared without interrupt");
  a_silence_len: assert property (
    $rose(drive_fault) |-> bits_seen >= SILENCE_BITS - 1)
    else $error("fault declared before the silence limit");
  a_irq_release: assert property (
    $rose(irq_n) |-> $past(!avs_waitrequest) || $past(!avs_waitrequest, 2))
    else $error("interrupt released without a register access");
  a_pads_hold: assert property (
    !tx_bit_en |=> $stable({tx_line_pos_out, tx_line_neg_out}))
    else $error("pads changed between bit strobes");
endmodule : tdm_top_assertions

// >>> tdm_line_model.sv
// line-side model: bit strobe, encoder marks and monitor wiring
`timescale 1ns/1ps
module tdm_line_model (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // scenario controls
  input  wire logic active,
  input  wire logic ext_wired,
  input  wire logic mon_force,
  // pads as seen on the board
  input  wire logic tx_line_pos_out,
  input  wire logic tx_line_neg_out,
  // toward the block
  output logic      tx_bit_en,
  output logic      tx_pos_data,
  output logic      tx_neg_data,
  output logic      monitor_pos_in,
  output logic      monitor_neg_in
);
  logic [1:0] div;
  logic       phase;

  ////////////////////////////////////////////////////////////////////////
  // one bit every four clocks; marks alternate polarity like real ami
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div   <= 2'h0;
      phase <= 1'b0;
    end else begin
      div   <= div + 2'h1;
      phase <= phase ^ tx_bit_en;
    end
  end
  assign tx_bit_en   = (div == 2'h3);
  assign tx_pos_data = active & ~phase;
  assign tx_neg_data = active & phase;

  ////////////////////////////////////////////////////////////////////////
  // wired: pins follow pads; else pulled to ground, or a stray toggle
  // that internal mode must ignore
  assign monitor_pos_in = ext_wired ? tx_line_pos_out : mon_force & div[0];
  assign monitor_neg_in = ext_wired ? tx_line_neg_out : 1'b0;
endmodule : tdm_line_model

// >>> tdm_top_tb_top.sv
// self-checking bench for the transmit drive monitor
`timescale 1ns/1ps
module tdm_top_tb_top;
  localparam int          SB   = 4; // short limit keeps the run brief
  localparam logic [15:0] A_IS = {tdm_pkg::IDX_INT_STATUS, 2'b00};
  localparam logic [15:0] A_AL = {tdm_pkg::IDX_ALARM, 2'b00};
  localparam logic [15:0] A_TC = {tdm_pkg::IDX_TX_CTRL, 2'b00};
  localparam logic [15:0] A_IM = {tdm_pkg::IDX_INT_MASK, 2'b00};
  logic                  ref_clk   = 1'b0;
  logic                  rst_n     = 1'b0;
  logic                  clk_en    = 1'b1;
  tdm_pkg::tdm_avs_req_t avs       = '0;
  tdm_pkg::tdm_alarm_t   alarms    = '0;
  logic                  active    = 1'b1;
  logic                  ext_wired = 1'b1;
  logic                  mon_force = 1'b0;
  logic [31:0]           avs_readdata;
  logic [1:0]            avs_response;
  logic                  avs_waitrequest;
  logic                  tx_bit_en, tx_pos_data, tx_neg_data;
  logic                  tx_line_pos_out, tx_line_neg_out;
  logic                  transmit_level_select, drive_fault, irq_n;
  logic                  monitor_pos_in, monitor_neg_in;
  logic [7:0]            q;
  logic [1:0]            r;
  int                    err_count  = 0;
  int                    n_compared = 0;

  always #5 ref_clk = ~ref_clk;

  tdm_top #(.SILENCE_BITS(SB)) dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
    .clk_en(clk_en), .avs(avs), .avs_readdata(avs_readdata),
    .avs_response(avs_response), .avs_waitrequest(avs_waitrequest),
    .tx_bit_en(tx_bit_en), .tx_pos_data(tx_pos_data),
    .tx_neg_data(tx_neg_data), .tx_line_pos_out(tx_line_pos_out),
    .tx_line_neg_out(tx_line_neg_out),
    .transmit_level_select(transmit_level_select),
    .monitor_pos_in(monitor_pos_in), .monitor_neg_in(monitor_neg_in),
    .alarms(alarms), .drive_fault(drive_fault), .irq_n(irq_n));

  tdm_line_model line_u (.ref_clk(ref_clk), .rst_n(rst_n), .active(active),
    .ext_wired(ext_wired), .mon_force(mon_force),
    .tx_line_pos_out(tx_line_pos_out), .tx_line_neg_out(tx_line_neg_out),
    .tx_bit_en(tx_bit_en), .tx_pos_data(tx_pos_data),
    .tx_neg_data(tx_neg_data), .monitor_pos_in(monitor_pos_in),
    .monitor_neg_in(monitor_neg_in));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one avalon transfer; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [15:0] a, logic [7:0] d);
    avs <= '{read: !wr, write: wr, address: a, writedata: {24'h0, d},
             byteenable: 4'h1};
    // no local limit: only the watchdog may end a stalled wait
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    r = avs_response;
    avs <= '0;
    @(posedge ref_clk);
  endtask : bus

  task automatic rdchk(input string nm, logic [15:0] a, logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk(nm, q, exp);
    chk("resp ok", {6'h0, r}, {6'h0, tdm_pkg::RESP_OK});
  endtask : rdchk

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cyc

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    cyc(2);
    rdchk("ctrl reset", A_TC, tdm_pkg::TXC_RST);
    rdchk("mask reset", A_IM, tdm_pkg::INT_MASK_RST);
    rdchk("status reset", A_IS, tdm_pkg::INT_STAT_RST);
    // encoder silent: any marks on the pads now come from all-ones
    active <= 1'b0;
    bus(1'b1, A_TC, 8'hff);
    rdchk("ctrl rw bits", A_TC, tdm_pkg::TXC_WMASK);
    chk("level pin", {7'h0, transmit_level_select}, 8'h01);
    cyc(4);
    chk("ones marks", {7'h0, tx_line_pos_out ^ tx_line_neg_out}, 8'h01);
    active <= 1'b1;
    bus(1'b1, A_TC, 8'h20);
    chk("level off", {7'h0, transmit_level_select}, 8'h00);
    ext_wired <= 1'b0;
    cyc(60);
    chk("fault idle", {7'h0, drive_fault}, 8'h00);
    rdchk("alarm quiet", A_AL, 8'h00);
    active    <= 1'b0;
    mon_force <= 1'b1;
    cyc(40);
    chk("fault set", {7'h0, drive_fault}, 8'h01);
    chk("irq on set", {7'h0, irq_n}, 8'h00);
    rdchk("alarm fault", A_AL, 8'h01);
    rdchk("status set", A_IS, 8'h01);
    rdchk("status cleared", A_IS, 8'h00);
    cyc(2);
    chk("irq released", {7'h0, irq_n}, 8'h01);
    mon_force <= 1'b0;
    active    <= 1'b1;
    cyc(20);
    chk("fault gone", {7'h0, drive_fault}, 8'h00);
    chk("irq on clear", {7'h0, irq_n}, 8'h00);
    rdchk("status on clear", A_IS, 8'h01);
    bus(1'b1, A_TC, 8'h00);
    cyc(40);
    chk("grounded pins", {7'h0, drive_fault}, 8'h01);
    ext_wired <= 1'b1;
    cyc(20);
    chk("pins wired", {7'h0, drive_fault}, 8'h00);
    // enable low freezes the pads and counter, so silence does not count
    clk_en <= 1'b0;
    active <= 1'b0;
    cyc(40);
    chk("frozen", {7'h0, drive_fault}, 8'h00);
    clk_en <= 1'b1;
    active <= 1'b1;
    cyc(8);
    bus(1'b1, A_IS, 8'h01);
    rdchk("status w1c", A_IS, 8'h00);
    bus(1'b1, A_IM, 8'h0d);
    alarms <= 5'h01;
    cyc(4);
    chk("irq masked", {7'h0, irq_n}, 8'h01);
    bus(1'b1, A_IM, 8'h0f);
    cyc(2);
    chk("irq unmasked", {7'h0, irq_n}, 8'h00);
    bus(1'b1, A_AL, 8'hff);
    rdchk("alarm ro", A_AL, 8'h02);
    alarms <= 5'h1f;
    cyc(4);
    rdchk("alarm all", A_AL, 8'h3e);
    rdchk("status all", A_IS, 8'h0e);
    rdchk("status gone", A_IS, 8'h00);
    bus(1'b0, A_AL + 16'h1, 8'h00);
    chk("decode answer", {6'h0, r}, {6'h0, tdm_pkg::RESP_DECODE});
    test_done();
  end

  // watchdog: whole sequence needs well under a thousand clocks
  initial begin
    repeat (5000) @(posedge ref_clk);
    chk("watchdog", 8'h00, 8'h01);
    test_done();
  end
endmodule : tdm_top_tb_top

bind tdm_top tdm_top_assertions #(.SILENCE_BITS(SILENCE_BITS)) chk_u (
  .ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .avs(avs),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .tx_bit_en(tx_bit_en), .tx_line_pos_out(tx_line_pos_out),
  .tx_line_neg_out(tx_line_neg_out),
  .transmit_level_select(transmit_level_select),
  .drive_fault(drive_fault), .irq_n(irq_n));
